// file: rtl/ppl_address_data_port.sv
// Purpose: Port 0 pin logic: latches, direction, open drain, bus use.
// Assumes: Pins arrive unsynchronised; a two-flop synchroniser inside the block samples them.
// Notes:   Pin outputs are registered, so pins follow one cycle late.
`timescale 1ns/1ps

// Notes on behaviour
// - Sample every pin each state time
// - Input pin: write latch, read pin
// - Input pin modify uses pin level
// - Output pin: drive latch, read latch
// - Output pin modify uses latch value
// - Direction bit: 0 input, 1 output
// - Open drain drives low only
// - Open-drain bits reset to push/pull
// - Open drain only on ports 2,3,6; this port 0 block still fits it when HAS_OD is set
// - Latch ANDed with alternate output
// - Alternate input sees pin level
// - Directions reset to input
// - Bus mode switches direction itself
// - Halves written independently
// - 8-bit demux bus uses low half
// - Reset: inputs with pullups, strap sampled
// - Release loads config and readback
// - Release drops pullups, enters mode
// - Mux cycle: address, then data
// - 8-bit word takes two cycles
// - Demux cycle carries data only
// - Bus off restores software direction
module ppl_address_data_port #(
	parameter bit HAS_OD = 1'b0 // Open drain fitted on this port
) (
	// Clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        clkEn,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	// Port pins
	input  wire logic [15:0] p0In,
	output logic      [15:0] p0Out,
	output logic      [15:0] p0OeN,
	output logic             p0PullEn,
	// Alternate functions
	input  wire logic [15:0] altOut,
	output logic      [15:0] altIn,
	// External bus requests
	input  wire logic        xReq,
	input  wire logic        xWrite,
	input  wire logic        xWord,
	input  wire logic [15:0] xAddr,
	input  wire logic [15:0] xWdata,
	output logic      [15:0] xRdata,
	output logic             xDone,
	output logic             xBusy,
	// Bus strobes
	output logic             busAle,
	output logic             busRdN,
	output logic             busWrN
);
	// ****************************************
	// Types and state
	// ****************************************
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_ADDR = 4'h2,
		S_DATA = 4'h4,
		S_DONE = 4'h8
	} ppl_state_t;

	ppl_state_t  state_q;    // Bus cycle state
	logic [15:0] pinMeta_q;  // First sync stage
	logic [15:0] pinSync_q;  // Sampled pin level
	logic [15:0] latch_q;    // Output latch, both halves
	logic [15:0] dir_q;      // Direction bits
	logic [15:0] odSel_q;    // Open-drain select
	logic [7:0]  busCfg_q;   // First bus config
	logic [7:0]  strap_q;    // Startup readback
	logic        cfgDone_q;  // Strap captured
	logic [15:0] cAddr_q;    // Current cycle address
	logic [15:0] cWdata_q;   // Write data
	logic        cWrite_q;   // Cycle is a write
	logic        cWord_q;    // Cycle is a word
	logic        second_q;   // Second byte pass
	logic [2:0]  dCnt_q;     // Data phase counter
	logic [15:0] drvOut;     // Next pin value
	logic [15:0] drvOeN;     // Next pin enables
	logic [15:0] busLines;   // Lines owned by the bus
	logic [15:0] readPort;   // Port read value
	logic        busOn;      // External bus active
	logic        narrow;     // 8-bit data bus

	// Decode of a register write to one offset
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = regWr && (a == ofs);
	endfunction

	assign busOn  = cfgDone_q && busCfg_q[ppl_pkg::CFG_EN];
	assign narrow = !busCfg_q[ppl_pkg::CFG_W16];
	// High half stays free only for the 8-bit demux bus
	assign busLines = (narrow && !busCfg_q[ppl_pkg::CFG_MUX]) ?
		16'h00FF : 16'hFFFF;

	// ****************************************
	// Pin sampling
	// ****************************************
	// No reset here, so the strap level is already present at release
	always_ff @(posedge clk_sys)
	begin
		if (clkEn)
		begin
			pinMeta_q <= p0In;
			pinSync_q <= pinMeta_q;
		end
	end

	// Alternate input follows the pin, so a driven latch is seen too
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			altIn <= 16'h0000;
		else if (clkEn)
			altIn <= pinSync_q;
	end

	// ****************************************
	// Strap capture at reset release
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cfgDone_q <= 1'b0;
			p0PullEn  <= 1'b1;
			busCfg_q  <= ppl_pkg::CFG_RST;
			strap_q   <= 8'h00;
		end
		else if (clkEn)
		begin
			if (!cfgDone_q)
			begin
				// First edge after release takes the pulled-up strap
				cfgDone_q <= 1'b1;
				busCfg_q  <= pinSync_q[7:0];
				strap_q   <= pinSync_q[15:8];
				p0PullEn  <= 1'b0;
			end
			else if (hit(regAddr, ppl_pkg::OFS_BUSCFG))
				busCfg_q <= regWdata[7:0];
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	// Each half has its own strobe; the other half is untouched
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			latch_q <= 16'h0000;
		else if (clkEn)
		begin
			// Writes land in the latch whatever the direction
			if (hit(regAddr, ppl_pkg::OFS_DATA_LO))
				latch_q[7:0] <= regWdata[7:0];
			if (hit(regAddr, ppl_pkg::OFS_DATA_HI))
				latch_q[15:8] <= regWdata[7:0];
		end
	end

	// Directions start as inputs; bus mode leaves them alone
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			dir_q <= 16'h0000;
		else if (clkEn)
		begin
			if (hit(regAddr, ppl_pkg::OFS_DIR_LO))
				dir_q[7:0] <= regWdata[7:0];
			if (hit(regAddr, ppl_pkg::OFS_DIR_HI))
				dir_q[15:8] <= regWdata[7:0];
		end
	end

	// Open-drain select exists only where the port has it
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			odSel_q <= ppl_pkg::ODSEL_RST;
		else if (clkEn && HAS_OD && hit(regAddr, ppl_pkg::OFS_ODSEL))
			odSel_q <= regWdata;
	end

	// Output lines read the latch, input lines read the pin, which
	// makes a read-modify-write take the right source per line
	assign readPort = (dir_q & latch_q) | (~dir_q & pinSync_q);

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			regRdata <= 16'h0000;
		else if (clkEn)
		begin
			regRdata <= 16'h0000;
			if (regRd)
			begin
				if (regAddr == ppl_pkg::OFS_DATA_LO)
					regRdata <= {8'h00, readPort[7:0]};
				else if (regAddr == ppl_pkg::OFS_DATA_HI)
					regRdata <= {8'h00, readPort[15:8]};
				else if (regAddr == ppl_pkg::OFS_DIR_LO)
					regRdata <= {8'h00, dir_q[7:0]};
				else if (regAddr == ppl_pkg::OFS_DIR_HI)
					regRdata <= {8'h00, dir_q[15:8]};
				else if (regAddr == ppl_pkg::OFS_ODSEL)
					regRdata <= odSel_q;
				else if (regAddr == ppl_pkg::OFS_BUSCFG)
					regRdata <= {8'h00, busCfg_q};
				else if (regAddr == ppl_pkg::OFS_STRAP)
					regRdata <= {8'h00, strap_q};
			end
		end
	end

	// ****************************************
	// External bus cycle
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q  <= S_IDLE;
			cAddr_q  <= 16'h0000;
			cWdata_q <= 16'h0000;
			cWrite_q <= 1'b0;
			cWord_q  <= 1'b0;
			second_q <= 1'b0;
			dCnt_q   <= 3'h0;
			xRdata   <= 16'h0000;
			xDone    <= 1'b0;
			xBusy    <= 1'b0;
		end
		else if (clkEn)
		begin
			xDone <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					// Requests arriving while the bus is off are ignored
					if (xReq && busOn)
					begin
						cAddr_q  <= xAddr;
						cWdata_q <= xWdata;
						cWrite_q <= xWrite;
						cWord_q  <= xWord;
						second_q <= 1'b0;
						xBusy    <= 1'b1;
						dCnt_q   <= 3'h0;
						if (busCfg_q[ppl_pkg::CFG_MUX])
							state_q <= S_ADDR;
						else
							state_q <= S_DATA;
					end
				end
				S_ADDR:
					state_q <= S_DATA;
				S_DATA:
				begin
					dCnt_q <= dCnt_q + 3'h1;
					if (dCnt_q == ppl_pkg::DATA_CYC - 3'h1)
					begin
						dCnt_q <= 3'h0;
						if (!cWrite_q)
						begin
							if (!narrow)
								xRdata <= pinSync_q;
							else if (second_q)
								xRdata[15:8] <= pinSync_q[7:0];
							else
								xRdata <= {8'h00, pinSync_q[7:0]};
						end
						// Low byte first, then the high byte
						if (narrow && cWord_q && !second_q)
						begin
							second_q <= 1'b1;
							cAddr_q  <= cAddr_q + 16'h0001;
							state_q  <= busCfg_q[ppl_pkg::CFG_MUX] ? S_ADDR : S_DATA;
						end
						else
							state_q <= S_DONE;
					end
				end
				S_DONE:
				begin
					xDone   <= 1'b1;
					xBusy   <= 1'b0;
					state_q <= S_IDLE;
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	// Per line: software direction and latch, or the bus owning it
	always_comb
	begin
		drvOut = 16'h0000;
		drvOeN = 16'hFFFF;
		for (int i = 0; i < 16; i++)
		begin
			if (busOn && busLines[i])
			begin
				// Hardware owns direction while the bus is on
				if (state_q == S_ADDR)
				begin
					drvOut[i] = cAddr_q[i];
					drvOeN[i] = 1'b0;
				end
				else if (state_q == S_DATA && cWrite_q)
				begin
					drvOut[i] = (narrow && second_q) ? cWdata_q[8 + (i % 8)] :
						cWdata_q[i];
					drvOeN[i] = 1'b0;
				end
			end
			else if (!cfgDone_q)
				drvOeN[i] = 1'b1;
			else if (dir_q[i])
			begin
				// Bus off: last software direction applies again
				drvOut[i] = latch_q[i] & altOut[i];
				drvOeN[i] = 1'b0;
				if (odSel_q[i] && drvOut[i])
					drvOeN[i] = 1'b1;
			end
		end
	end

	// Registered so every pin output comes straight from a flop
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			p0Out <= 16'h0000;
			p0OeN <= 16'hFFFF;
		end
		else if (clkEn)
		begin
			p0Out <= drvOut;
			p0OeN <= drvOeN;
		end
	end

	// Strobes follow the cycle phase
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			busAle <= 1'b0;
			busRdN <= 1'b1;
			busWrN <= 1'b1;
		end
		else if (clkEn)
		begin
			busAle <= (state_q == S_ADDR);
			busRdN <= !(state_q == S_DATA && !cWrite_q);
			busWrN <= !(state_q == S_DATA && cWrite_q);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_pullOff;
		@(posedge clk_sys) disable iff (!rstn)
		cfgDone_q |-> !p0PullEn;
	endproperty
	a_pullOff: assert property (p_pullOff) else $error("pullups left on");

	property p_strap;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(cfgDone_q) |-> strap_q == $past(pinSync_q[15:8]);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not captured");

	property p_rdLatch;
		@(posedge clk_sys) disable iff (!rstn)
		clkEn && regRd && regAddr == ppl_pkg::OFS_DATA_LO |=>
			regRdata[7:0] == (($past(dir_q[7:0]) & $past(latch_q[7:0])) |
			(~$past(dir_q[7:0]) & $past(pinSync_q[7:0])));
	endproperty
	a_rdLatch: assert property (p_rdLatch) else $error("port read wrong");

	property p_addrFirst;
		@(posedge clk_sys) disable iff (!rstn)
		clkEn && state_q == S_ADDR |=> p0Out[7:0] == $past(cAddr_q[7:0]) &&
			p0OeN[7:0] == 8'h00 ##1 (busWrN == !cWrite_q) && (busRdN == cWrite_q);
	endproperty
	a_addrFirst: assert property (p_addrFirst) else $error("address phase");

	property p_readHiZ;
		@(posedge clk_sys) disable iff (!rstn)
		clkEn && state_q == S_DATA && !cWrite_q |=> p0OeN[7:0] == 8'hFF;
	endproperty
	a_readHiZ: assert property (p_readHiZ) else $error("read not hi-z");

	property p_odLow;
		@(posedge clk_sys) disable iff (!rstn)
		!busOn |-> (~p0OeN & p0Out & $past(odSel_q)) == 16'h0000;
	endproperty
	a_odLow: assert property (p_odLow) else $error("open drain drove high");

	property p_odNone;
		@(posedge clk_sys) disable iff (!rstn)
		!HAS_OD |-> odSel_q == 16'h0000;
	endproperty
	a_odNone: assert property (p_odNone) else $error("open drain on port");

	property p_inHiZ;
		@(posedge clk_sys) disable iff (!rstn)
		clkEn && !busOn && cfgDone_q |=> (p0OeN | $past(dir_q)) == 16'hFFFF;
	endproperty
	a_inHiZ: assert property (p_inHiZ) else $error("input line driven");

	property p_twoPass;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(second_q) |-> narrow && cWord_q;
	endproperty
	a_twoPass: assert property (p_twoPass) else $error("bad second pass");
endmodule

// file: rtl/ppl_pkg.sv
// Purpose: Constants shared by the port 0 pin logic.
// Assumes: 16-bit register port, one clock.
// Notes:   Offsets are register indexes on the plain register port.
package ppl_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [3:0] OFS_DATA_LO = 4'h0; // Low half output latch
	localparam logic [3:0] OFS_DATA_HI = 4'h1; // High half output latch
	localparam logic [3:0] OFS_DIR_LO  = 4'h2; // Low half direction
	localparam logic [3:0] OFS_DIR_HI  = 4'h3; // High half direction
	localparam logic [3:0] OFS_ODSEL   = 4'h4; // Open-drain select
	localparam logic [3:0] OFS_BUSCFG  = 4'h5; // First bus config
	localparam logic [3:0] OFS_STRAP   = 4'h6; // Startup readback, read only

	// ****************************************
	// Bus config fields and reset values
	// ****************************************
	localparam int        CFG_EN      = 0;     // External bus enabled
	localparam int        CFG_MUX     = 1;     // Multiplexed address/data
	localparam int        CFG_W16     = 2;     // 16-bit data bus
	localparam logic [7:0] CFG_RST    = 8'h00; // Before the strap load
	localparam logic [15:0] ODSEL_RST = 16'h0000; // Push/pull everywhere

	// ****************************************
	// Timing
	// ****************************************
	localparam logic [2:0] DATA_CYC   = 3'h4;  // Data phase, covers sync delay
endpackage

// file: tb/ppl_address_data_port_test.sv
// Purpose: Self-checking bench for the port 0 pin logic.
// Assumes: Expected values come from a bench model of latches and lines.
// Notes:   A second copy with open drain fitted shows that drive mode.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t ns value mismatch %h vs %h", $time, (a), (e)); end end
module ppl_address_data_port_test;
	localparam logic [15:0] STRAP = 16'h5AFE; // Bus off, readback 5A
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdata, p0Out, p0OeN, altIn, xRdata, pinLvl, aleAddr, wrData;
	logic        p0PullEn, xDone, xBusy, busAle, busRdN, busWrN;
	logic [15:0] odRdata, odOut, odOeN;
	logic        clkEn = 1'b1;
	logic [15:0] altOut = 16'hFFFF;
	logic        xReq = 1'b0;
	logic        xWrite = 1'b0;
	logic        xWord = 1'b0;
	logic [15:0] xAddr = 16'h0000;
	logic [15:0] xWdata = 16'h0000;
	logic [15:0] extDrv = STRAP;  // Pulldowns set the strap
	logic [15:0] extEn = ~STRAP;
	logic [31:0] seed = 32'h427191EE;
	int          n_errors = 0;
	int          n_checks = 0;
	logic [15:0] lat, dir, alt, ext, rd, v, a;

	// Clock at 50 MHz
	always #10 clk_sys = ~clk_sys;

	ppl_address_data_port #(.HAS_OD(1'b0)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .p0In(pinLvl), .p0Out(p0Out), .p0OeN(p0OeN),
		.p0PullEn(p0PullEn), .altOut(altOut), .altIn(altIn), .xReq(xReq),
		.xWrite(xWrite), .xWord(xWord), .xAddr(xAddr), .xWdata(xWdata),
		.xRdata(xRdata), .xDone(xDone), .xBusy(xBusy), .busAle(busAle),
		.busRdN(busRdN), .busWrN(busWrN));

	ppl_pin_model far_u (.clk_sys(clk_sys), .p0Out(p0Out), .p0OeN(p0OeN),
		.p0PullEn(p0PullEn), .busAle(busAle), .busRdN(busRdN), .busWrN(busWrN),
		.extDrv(extDrv), .extEn(extEn), .pinLvl(pinLvl), .aleAddr(aleAddr),
		.wrData(wrData));

	// Second copy with open drain fitted, sharing the register port
	ppl_address_data_port #(.HAS_OD(1'b1)) odDut_u (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(odRdata), .p0In(pinLvl), .p0Out(odOut), .p0OeN(odOeN),
		.p0PullEn(), .altOut(altOut), .altIn(), .xReq(xReq),
		.xWrite(xWrite), .xWord(xWord), .xAddr(xAddr), .xWdata(xWdata),
		.xRdata(), .xDone(), .xBusy(), .busAle(),
		.busRdN(), .busWrN());

	// Fixed-seed xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Memory contents as the far side holds them
	function automatic logic [7:0] byteOf(input logic [15:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h3C;
	endfunction

	// Verdict and end of run
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One-cycle register write
	task automatic regWrite(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= ad;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	// Register read, data taken in the following cycle
	task automatic regRead(input logic [3:0] ad, output logic [15:0] d);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= ad;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask

	// External bus request, waits for completion under a bound
	// n is the expected number of cycles from the taking edge to xDone
	task automatic busXfer(input logic w, input logic wd, input logic [15:0] ad,
		input logic [15:0] d, input int n);
		int k;
		@(posedge clk_sys);
		xReq <= 1'b1;
		xWrite <= w;
		xWord <= wd;
		xAddr <= ad;
		xWdata <= d;
		@(posedge clk_sys);
		xReq <= 1'b0;
		k = 0;
		#1 `CHK(xBusy, 1'b1)
		while (xDone !== 1'b1 && k < 40)
		begin
			@(posedge clk_sys);
			#1 k++;
		end
		// A hang counts here and the run goes on to the closing report
		if (xDone !== 1'b1)
		begin
			n_errors++;
			$display("[FAIL] %0t ns bus transfer never completed", $time);
		end
		`CHK(k, n)
		`CHK(xBusy, 1'b0)
	endtask

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_sys);
		#1 `CHK(p0OeN, 16'hFFFF)
		`CHK(p0PullEn, 1'b1)
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		extEn <= 16'h0000;
		#1 `CHK(p0PullEn, 1'b0)
		regRead(ppl_pkg::OFS_STRAP, v);
		`CHK(v, {8'h00, STRAP[15:8]})
		regRead(ppl_pkg::OFS_BUSCFG, v);
		`CHK(v, {8'h00, STRAP[7:0]})
		regWrite(ppl_pkg::OFS_STRAP, 16'h0000);
		regRead(ppl_pkg::OFS_STRAP, v);
		`CHK(v, {8'h00, STRAP[15:8]})
		regRead(ppl_pkg::OFS_DIR_LO, v);
		`CHK(v, 16'h0000)
		regRead(ppl_pkg::OFS_ODSEL, v);
		`CHK(odRdata, ppl_pkg::ODSEL_RST)
		regWrite(ppl_pkg::OFS_ODSEL, 16'hFFFF);
		regRead(ppl_pkg::OFS_ODSEL, v);
		`CHK(v, ppl_pkg::ODSEL_RST)
		`CHK(odRdata, 16'hFFFF)
		regRead(4'hF, v);
		`CHK(v, 16'h0000)
		$display("Test reset and register map done");
		// Random latches, directions, alternate data and external levels
		for (int n = 0; n < 6; n++)
		begin
			lat = 16'(rnd());
			dir = 16'(rnd());
			alt = 16'(rnd());
			ext = 16'(rnd());
			regWrite(ppl_pkg::OFS_DATA_LO, {8'h00, lat[7:0]});
			regWrite(ppl_pkg::OFS_DATA_HI, {8'h00, lat[15:8]});
			altOut <= alt;
			extDrv <= ext;
			extEn <= ~dir;
			regWrite(ppl_pkg::OFS_DIR_LO, {8'h00, dir[7:0]});
			regWrite(ppl_pkg::OFS_DIR_HI, {8'h00, dir[15:8]});
			repeat (6) @(posedge clk_sys);
			#1 `CHK(p0OeN, ~dir)
			`CHK(p0Out & dir, lat & alt & dir)
			`CHK(altIn, (dir & lat & alt) | (~dir & ext))
			// Open-drain copy: a high latch and a high alternate output release the line
			`CHK(odOeN, ~(dir & ~(lat & alt)))
			`CHK(odOut & ~odOeN, 16'h0000)
			rd = (dir & lat) | (~dir & ext);
			regRead(ppl_pkg::OFS_DATA_HI, v);
			`CHK(v, {8'h00, rd[15:8]})
			regRead(ppl_pkg::OFS_DATA_LO, v);
			`CHK(v, {8'h00, rd[7:0]})
			// Modify the low half from what was read
			regWrite(ppl_pkg::OFS_DATA_LO, v ^ 16'h00FF);
			lat[7:0] = rd[7:0] ^ 8'hFF;
			regWrite(ppl_pkg::OFS_DIR_LO, 16'h00FF);
			dir[7:0] = 8'hFF;
			repeat (6) @(posedge clk_sys);
			#1 `CHK(p0Out[7:0], lat[7:0] & alt[7:0])
			regRead(ppl_pkg::OFS_DATA_LO, v);
			`CHK(v, {8'h00, lat[7:0]})
		end
		// Frozen enable: a write strobe must leave the register untouched
		@(posedge clk_sys);
		clkEn <= 1'b0;
		regWrite(ppl_pkg::OFS_DIR_HI, {8'h00, ~dir[15:8]});
		clkEn <= 1'b1;
		regRead(ppl_pkg::OFS_DIR_HI, v);
		`CHK(v, {8'h00, dir[15:8]})
		$display("Test general purpose lines done");
		// Bus modes: the config and low direction registers are written, never a latch
		regWrite(ppl_pkg::OFS_BUSCFG, 16'h0007);
		a = 16'(rnd()) & 16'hFFFE;
		busXfer(1'b0, 1'b1, a, 16'h0000, 2 + ppl_pkg::DATA_CYC);
		`CHK(xRdata, {byteOf(a + 16'h0001), byteOf(a)})
		`CHK(aleAddr, a)
		v = 16'(rnd());
		busXfer(1'b1, 1'b1, a ^ 16'h0100, v, 2 + ppl_pkg::DATA_CYC);
		`CHK(wrData, v)
		`CHK(aleAddr, a ^ 16'h0100)
		regWrite(ppl_pkg::OFS_BUSCFG, 16'h0003);
		busXfer(1'b0, 1'b1, a, 16'h0000, 3 + 2 * ppl_pkg::DATA_CYC);
		`CHK(xRdata, {byteOf(a + 16'h0001), byteOf(a)})
		regWrite(ppl_pkg::OFS_BUSCFG, 16'h0001);
		regWrite(ppl_pkg::OFS_DIR_LO, 16'h000F);
		busXfer(1'b1, 1'b0, a, {8'h00, v[15:8]}, 1 + ppl_pkg::DATA_CYC);
		`CHK(wrData[7:0], v[15:8])
		`CHK(p0OeN[15:8], ~dir[15:8])
		regWrite(ppl_pkg::OFS_BUSCFG, 16'h0000);
		repeat (4) @(posedge clk_sys);
		#1 `CHK(p0OeN, ~{dir[15:8], 8'h0F})
		$display("Test external bus modes done");
		conclude();
	end
endmodule

// file: tb/ppl_pin_model.sv
// Purpose: Far side of port 0: straps, external drivers, pullups, memory.
// Assumes: Bus address is latched from the lines while busAle is high.
// Notes:   Floating lines toggle each cycle, so no stale level is read.
`timescale 1ns/1ps
module ppl_pin_model (
	// Clock
	input  wire logic        clk_sys,
	// Device pins and strobes
	input  wire logic [15:0] p0Out,
	input  wire logic [15:0] p0OeN,
	input  wire logic        p0PullEn,
	input  wire logic        busAle,
	input  wire logic        busRdN,
	input  wire logic        busWrN,
	// External drivers set by the bench
	input  wire logic [15:0] extDrv,
	input  wire logic [15:0] extEn,
	// Resolved lines and captured bus values
	output logic      [15:0] pinLvl,
	output logic      [15:0] aleAddr,
	output logic      [15:0] wrData
);
	logic [15:0] togQ = 16'h0000; // Pattern for released lines
	logic [15:0] memVal;          // Memory answer at the latched address

	// Byte-wide memory contents, derived from the address
	function automatic logic [7:0] memByte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction

	assign memVal = {memByte(aleAddr + 16'h0001), memByte(aleAddr)};

	// Line level: device drive wins, then memory, straps, pullups
	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			if (!p0OeN[i])
				pinLvl[i] = p0Out[i];
			else if (!busRdN)
				pinLvl[i] = memVal[i];
			else if (extEn[i])
				pinLvl[i] = extDrv[i];
			else if (p0PullEn)
				pinLvl[i] = 1'b1;
			else
				pinLvl[i] = togQ[i]; // Nobody drives: keep it moving
		end
	end

	// Capture address phase and write data as a memory would
	always @(posedge clk_sys)
	begin
		togQ <= ~togQ;
		if (busAle)
			aleAddr <= pinLvl;
		if (!busWrN)
			wrData <= pinLvl;
	end
endmodule
